// ---- design/csg_pkg.sv ----
package csg_pkg;

    // axi4-lite register map (byte addresses)
    localparam logic [7:0] CSG_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CSG_ADDR_CFG = 8'h04;
    localparam logic [7:0] CSG_ADDR_STATUS = 8'h08;
    localparam logic [7:0] CSG_ADDR_ID = 8'h0C;

    // ctrl fields
    localparam int CSG_CTRL_SEL_LSB = 0;
    localparam int CSG_CTRL_GENA_BIT = 2;
    localparam int CSG_CTRL_RENA_BIT = 3;
    localparam int CSG_CTRL_XENA_BIT = 4;
    localparam int CSG_CTRL_USER_BIT = 5;

    // cfg fields
    localparam int CSG_CFG_GSEL_LSB = 0;
    localparam int CSG_CFG_RSEL_LSB = 2;
    localparam int CSG_CFG_XSEL_LSB = 4;
    localparam int CSG_CFG_GDYN_BIT = 6;
    localparam int CSG_CFG_GUSED_BIT = 7;
    localparam int CSG_CFG_RUSED_BIT = 8;
    localparam int CSG_CFG_XUSED_BIT = 9;
    localparam int CSG_CFG_XROUTE_BIT = 10;
    localparam int CSG_CFG_XFB_BIT = 11;

    localparam logic [31:0] CSG_CTRL_RST = 32'h0000001C;
    localparam logic [31:0] CSG_CFG_RST = 32'h00000000;
    // arbitrary block identity value
    localparam logic [31:0] CSG_ID_VALUE = 32'h00C5_0001;

    localparam logic [1:0] CSG_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSG_RESP_SLVERR = 2'h2;

    // mux input positions
    localparam logic [1:0] CSG_IN_PIN0 = 2'h0;
    localparam logic [1:0] CSG_IN_PIN1 = 2'h1;
    localparam logic [1:0] CSG_IN_LOOP0 = 2'h2;
    localparam logic [1:0] CSG_IN_LOOP1 = 2'h3;

endpackage

// ---- design/csg_gate.sv ----
`timescale 1ns/1ps
// one network: four-input source mux and glitch-free enable gate
module csg_gate
    import csg_pkg::*;
(
    // source side
    input wire logic [3:0] src_i,
    input wire logic [1:0] sel_i,
    input wire logic ena_i,
    input wire logic rst_n_i,
    // network side
    output logic net_o,
    output logic ena_q_o
);
    import csg_pkg::*;

    logic src_clk;
    logic ena_q;

    assign src_clk = src_i[sel_i];

    // enable taken at the falling edge, so it only moves while the clock is low
    always_ff @(negedge src_clk) begin
        if (!rst_n_i) begin
            ena_q <= 1'b0;
        end else begin
            ena_q <= ena_i;
        end
    end

    // and-gate with a falling-edge registered enable: no runt high pulse
    assign net_o = src_clk & ena_q;
    assign ena_q_o = ena_q;

endmodule

// ---- design/csg_top.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module csg_top
    import csg_pkg::*;
(
    // system
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock sources
    input wire logic [1:0] dedicated_clock_pin_i,
    input wire logic [1:0] edge_clock_pin_i,
    input wire logic [1:0] loop_clk_i,
    input wire logic user_mode_i,
    input wire logic internal_sig_i,
    // networks
    output logic global_net_o,
    output logic regional_net_o,
    output logic ext_clk_pin_o,
    output logic relock_needed_o
);
    import csg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] next_ctrl;
    logic [31:0] next_cfg;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;
    logic user_mode;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return (a == CSG_ADDR_CTRL) || (a == CSG_ADDR_CFG) ||
               (a == CSG_ADDR_STATUS) || (a == CSG_ADDR_ID);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign do_write = aw_held && w_held && !bvalid;
    assign user_mode = user_mode_i;

    logic [3:0] net_ena_q;
    logic [31:0] status;
    assign status = {25'h0000000, ctrl[CSG_CTRL_USER_BIT], user_mode,
                     cfg[CSG_CFG_XFB_BIT], net_ena_q[2:0], 1'b0};

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_ctrl = ctrl;
        next_cfg = cfg;
        next_ctrl[CSG_CTRL_USER_BIT] = user_mode;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = CSG_RESP_OKAY;
            case (aw_addr)
                CSG_ADDR_CTRL: begin
                    next_ctrl = merge(ctrl, w_data, w_strb);
                    next_ctrl[CSG_CTRL_USER_BIT] = user_mode;
                end
                // configuration only loads outside user mode
                CSG_ADDR_CFG: begin
                    if (!user_mode) begin
                        next_cfg = merge(cfg, w_data, w_strb);
                    end else begin
                        next_bresp = CSG_RESP_SLVERR;
                    end
                end
                default: begin
                    next_bresp = known_addr(aw_addr) ? CSG_RESP_OKAY : CSG_RESP_SLVERR;
                end
            endcase
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = CSG_RESP_OKAY;
            case (s_axi_araddr)
                CSG_ADDR_CTRL: next_rdata = ctrl;
                CSG_ADDR_CFG: next_rdata = cfg;
                CSG_ADDR_STATUS: next_rdata = status;
                CSG_ADDR_ID: next_rdata = CSG_ID_VALUE;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = CSG_RESP_SLVERR;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl <= CSG_CTRL_RST;
            cfg <= CSG_CFG_RST;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= CSG_RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= CSG_RESP_OKAY;
        end else begin
            ctrl <= next_ctrl;
            cfg <= next_cfg;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection and enables
    logic [1:0] gsel;
    logic [1:0] rsel;
    logic [1:0] xsel;
    logic [2:0] ena;
    logic [2:0] net;
    logic [3:0] gsrc;
    logic [3:0] rsrc;
    logic [3:0] xsrc;

    // pins on inputs 0-1, loop outputs on 2-3
    assign gsrc = {loop_clk_i, dedicated_clock_pin_i};
    // regional block sees the top/bottom edge pins on inputs 0-1 in place of the dedicated pins, loop outputs on 2-3
    assign rsrc = {loop_clk_i, edge_clock_pin_i};
    assign xsrc = {loop_clk_i, dedicated_clock_pin_i};

    // dynamic field only honoured in user mode with dynamic select configured
    assign gsel = (user_mode && cfg[CSG_CFG_GDYN_BIT]) ?
                  ctrl[CSG_CTRL_SEL_LSB +: 2] : cfg[CSG_CFG_GSEL_LSB +: 2];
    assign rsel = cfg[CSG_CFG_RSEL_LSB +: 2];
    assign xsel = cfg[CSG_CFG_XSEL_LSB +: 2];

    // unused networks held off by configuration, dynamic enable on top
    assign ena[0] = cfg[CSG_CFG_GUSED_BIT] & ctrl[CSG_CTRL_GENA_BIT];
    assign ena[1] = cfg[CSG_CFG_RUSED_BIT] & ctrl[CSG_CTRL_RENA_BIT];
    assign ena[2] = cfg[CSG_CFG_XUSED_BIT] & ctrl[CSG_CTRL_XENA_BIT];

    // one control block per network
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_net
            csg_gate u_gate (
                .src_i(g == 0 ? gsrc : (g == 1 ? rsrc : xsrc)),
                .sel_i(g == 0 ? gsel : (g == 1 ? rsel : xsel)),
                .ena_i(ena[g]),
                .rst_n_i(rst_n_i),
                .net_o(net[g]),
                .ena_q_o(net_ena_q[g])
            );
        end
    endgenerate
    assign net_ena_q[3] = 1'b0;

    // loop clocks pass straight to the gates; loop counters never see enable
    assign global_net_o = net[0];
    assign regional_net_o = net[1];
    // dual-purpose pin: internal signal or gated clock
    assign ext_clk_pin_o = cfg[CSG_CFG_XROUTE_BIT] ? net[2] : internal_sig_i;
    // relock only flagged for external feedback while external net is off
    assign relock_needed_o = cfg[CSG_CFG_XFB_BIT] & ~net_ena_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_cfg_locked;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        user_mode ##1 user_mode |-> $stable(cfg);
    endproperty
    a_cfg_locked: assert property (p_cfg_locked) else $error("cfg changed in user mode");

    property p_gsel_static;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !user_mode |-> gsel == cfg[CSG_CFG_GSEL_LSB +: 2];
    endproperty
    a_gsel_static: assert property (p_gsel_static) else $error("dynamic select outside user");

    property p_gsel_dyn;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        user_mode && cfg[CSG_CFG_GDYN_BIT] |-> gsel == ctrl[CSG_CTRL_SEL_LSB +: 2];
    endproperty
    a_gsel_dyn: assert property (p_gsel_dyn) else $error("select field ignored");

    property p_unused_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg[CSG_CFG_GUSED_BIT] |-> !ena[0];
    endproperty
    a_unused_off: assert property (p_unused_off) else $error("unused net enabled");

    property p_cfg_write_err;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        do_write && aw_addr == CSG_ADDR_CFG && user_mode |=> bvalid && bresp == CSG_RESP_SLVERR;
    endproperty
    a_cfg_write_err: assert property (p_cfg_write_err) else $error("cfg write accepted");

    property p_xroute;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg[CSG_CFG_XROUTE_BIT] |-> ext_clk_pin_o == internal_sig_i;
    endproperty
    a_xroute: assert property (p_xroute) else $error("pin mux wrong");

    property p_relock;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg[CSG_CFG_XFB_BIT] |-> !relock_needed_o;
    endproperty
    a_relock: assert property (p_relock) else $error("relock without ext feedback");

    property p_net_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !net_ena_q[0] |-> !global_net_o;
    endproperty
    a_net_off: assert property (p_net_off) else $error("gated net toggling");

    property p_rnet_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !net_ena_q[1] |-> !regional_net_o;
    endproperty
    a_rnet_off: assert property (p_rnet_off) else $error("regional net toggling");

    property p_runused_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cfg[CSG_CFG_RUSED_BIT] |-> !ena[1];
    endproperty
    a_runused_off: assert property (p_runused_off) else $error("regional net enabled");

    property p_xnet_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !net_ena_q[2] |-> !net[2];
    endproperty
    a_xnet_off: assert property (p_xnet_off) else $error("ext net toggling");

    // user flag follows the mode pin one cycle later
    property p_ctrl_user;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ctrl[CSG_CTRL_USER_BIT] == $past(user_mode);
    endproperty
    a_ctrl_user: assert property (p_ctrl_user) else $error("user bit stale");

    c_write: cover property (@(posedge clk_sys_i) do_write);
    c_read: cover property (@(posedge clk_sys_i) rvalid && s_axi_rready);
    c_dyn: cover property (@(posedge clk_sys_i) user_mode && cfg[CSG_CFG_GDYN_BIT]);
    c_gated: cover property (@(posedge clk_sys_i) ena[0] ##1 !ena[0]);

endmodule

// ---- sim/csg_src_model.sv ----
`timescale 1ns/1ps
module csg_src_model (
    // clock sources
    output logic [1:0] pin_o,
    output logic [1:0] edge_o,
    output logic [1:0] loop_o
);
    // free-running sources on half-ns edges, clear of system clock edges
    initial begin
        pin_o = 2'h0;
        edge_o = 2'h0;
        loop_o = 2'h0;
        #0.5;
        fork
            forever #7 pin_o[0] = ~pin_o[0];
            forever #9 pin_o[1] = ~pin_o[1];
            forever #11 edge_o[0] = ~edge_o[0];
            forever #13 edge_o[1] = ~edge_o[1];
            forever #17 loop_o[0] = ~loop_o[0];
            forever #19 loop_o[1] = ~loop_o[1];
        join
    end
endmodule

// ---- sim/tb_clock_select_and_gate.sv ----
`timescale 1ns/1ps
module tb_clock_select_and_gate;
    import csg_pkg::*;
    logic clk, rst_n, awv, wv, bry, arv, rry, umode, isig;
    logic awr, wr_rdy, bv, arr, rv, g_net, r_net, x_net, relock;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, data;
    logic [1:0] br, rr, resp, pin, edg, loop;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int ctrl_m, cfg_m;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    csg_top u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .dedicated_clock_pin_i(pin),
        .edge_clock_pin_i(edg), .loop_clk_i(loop), .user_mode_i(umode),
        .internal_sig_i(isig), .global_net_o(g_net), .regional_net_o(r_net),
        .ext_clk_pin_o(x_net), .relock_needed_o(relock));

    csg_src_model u_src (.pin_o(pin), .edge_o(edg), .loop_o(loop));

    ////////////////////////////////////////////////////////////////////////////////
    task cmp(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awv && awr) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wr_rdy) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        while (!bv) @(posedge clk);
        r = br;
        bry <= 1'b0;
    endtask

    task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        d = rd;
        r = rr;
        rry <= 1'b0;
    endtask

    task put(input logic [7:0] a, input int v, input logic [1:0] e);
        wr(a, v, resp);
        cmp(resp, e);
    endtask

    // model of all three networks, sampled away from every source edge
    task chk_nets;
        logic [3:0] gs, rs;
        int gsel;
        logic xe;
        repeat (4) @(posedge clk);
        repeat (16) begin
            @(negedge clk);
            gs = {loop, pin};
            rs = {loop, edg};
            gsel = (umode && cfg_m[6]) ? (ctrl_m & 3) : (cfg_m & 3);
            xe = ctrl_m[4] & cfg_m[9];
            cmp(g_net, gs[gsel] & ctrl_m[2] & cfg_m[7]);
            cmp(r_net, rs[(cfg_m >> 2) & 3] & ctrl_m[3] & cfg_m[8]);
            cmp(x_net, cfg_m[10] ? (gs[(cfg_m >> 4) & 3] & xe) : isig);
            cmp(relock, cfg_m[11] & ~xe);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        {awv, wv, bry, arv, rry, umode, isig} = 7'h00;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h0;
        void'($urandom(32'hDFC6D2E7));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        ctrl_m = 32'h1C;
        cfg_m = 0;
        rdr(CSG_ADDR_CTRL, data, resp);
        cmp(data & 32'h3F, ctrl_m);
        rdr(CSG_ADDR_CFG, data, resp);
        cmp(data, cfg_m);
        rdr(CSG_ADDR_ID, data, resp);
        cmp(data, CSG_ID_VALUE);
        rdr(8'h10, data, resp);
        cmp(resp, CSG_RESP_SLVERR);
        cmp(data, 32'h0);
        chk_nets();
        $display("test reset done");
        for (int s = 0; s < 8; s++) begin
            cfg_m = (s & 3) | ($urandom & 32'h43C) | 32'h380;
            put(CSG_ADDR_CFG, cfg_m, CSG_RESP_OKAY);
            ctrl_m = $urandom & 32'h1C;
            put(CSG_ADDR_CTRL, ctrl_m, CSG_RESP_OKAY);
            isig <= 1'($urandom);
            chk_nets();
        end
        $display("test static select done");
        cfg_m = 32'hFC1;
        put(CSG_ADDR_CFG, cfg_m, CSG_RESP_OKAY);
        @(posedge clk);
        umode <= 1'b1;
        put(CSG_ADDR_CFG, 0, CSG_RESP_SLVERR);
        rdr(CSG_ADDR_CFG, data, resp);
        cmp(data, cfg_m);
        for (int s = 0; s < 4; s++) begin
            ctrl_m = s | 32'h0C | ((s & 1) << 4);
            put(CSG_ADDR_CTRL, ctrl_m, CSG_RESP_OKAY);
            chk_nets();
        end
        rdr(CSG_ADDR_CTRL, data, resp);
        cmp(data & 32'h3F, ctrl_m | 32'h20);
        rdr(CSG_ADDR_STATUS, data, resp);
        cmp(data, 32'h60 | ((cfg_m >> 7) & 32'h10) | ((ctrl_m & (cfg_m >> 5) & 32'h1C) >> 1));
        @(posedge clk);
        umode <= 1'b0;
        chk_nets();
        $display("test dynamic select done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        ctrl_m = 32'h1C;
        cfg_m = 0;
        chk_nets();
        $display("test second reset done");
        complete_run();
    end
endmodule
